// ---- shared/supervisor_regs.svh ----
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH

// ****************************************
// clock and timing figures
// ****************************************
`define SUP_CLK_HZ 25000000
`define SUP_RESET_TIMEOUT_MS 200
`define SUP_WATCHDOG_MS 1600
`define SUP_GATE_DELAY_US 28
`define SUP_DEBOUNCE_US 2

// cycle counts derived from the figures above
`define SUP_RESET_TIMEOUT_CYC (`SUP_RESET_TIMEOUT_MS * (`SUP_CLK_HZ / 1000))
`define SUP_WATCHDOG_CYC (`SUP_WATCHDOG_MS * (`SUP_CLK_HZ / 1000))
`define SUP_GATE_DELAY_CYC ((`SUP_GATE_DELAY_US * (`SUP_CLK_HZ / 1000) + 999) / 1000)
`define SUP_DEBOUNCE_CYC ((`SUP_DEBOUNCE_US * (`SUP_CLK_HZ / 1000) + 999) / 1000)

// ****************************************
// widths and synchroniser bit positions
// ****************************************
`define SUP_TIMER_W 32
`define SUP_SYNC_W 8
`define SUP_SYNC_SUPPLY_LOW 0
`define SUP_SYNC_LOW_LINE 1
`define SUP_SYNC_AUX_BELOW 2
`define SUP_SYNC_MR_N 3
`define SUP_SYNC_KICK 4
`define SUP_SYNC_KICK_FLOAT 5
`define SUP_SYNC_BACKUP 6
`define SUP_SYNC_CS_IN_N 7

`endif

// ---- shared/supervisor_pkg.sv ----
package supervisor_pkg;

  // chip-select gate states
  typedef enum logic [1:0] {
    GATE_PASS = 2'b00,
    GATE_PENDING = 2'b01,
    GATE_BLOCKED = 2'b10
  } gate_state_t;

endpackage

// ---- design/sync_2ff.sv ----
`timescale 1ns/1ns
`default_nettype none

module sync_2ff #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ---- design/cycle_timer.sv ----
`timescale 1ns/1ns
`default_nettype none

module cycle_timer #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic done
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  wire at_limit = (count_r == limit);

  // saturates at the limit so done stays up until cleared
  always_comb begin
    if (clear) begin
      count_nxt = '0;
    end else if (run && !at_limit) begin
      count_nxt = count_r + W'(1);
    end else begin
      count_nxt = count_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= '0;
      done <= 1'h0;
    end else begin
      count_r <= count_nxt;
      done <= !clear && (count_nxt == limit);
    end
  end

endmodule

`default_nettype wire

// ---- design/supervisor_reset_watchdog_cegate.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "supervisor_regs.svh"

// Functional notes
// - reset asserts while supply is low or manual reset is held low.
// - every reset lasts at least the 200ms timeout after its cause clears.
// - supply dipping low again restarts the timeout from zero.
// - manual reset low holds reset, then 200ms more after release.
// - active-high reset is always the complement of active-low reset.
// - a bouncing manual reset switch yields one clean reset.
// - no kick transition for 1.6s drives watchdog fault low.
// - reset or a kick edge outside reset clears timer, fault returns high.
// - watchdog timer held cleared during reset, counts from release.
// - supply low or floating kick disables watchdog, fault held high.
// - fault stays low until the next kick transition, reset or watchdog disable.
// - chip-select passes through normally, path disabled during reset.
// - power-down reset disables chip-select path 28us after reset asserts.
// - on power-up chip-select path stays disabled until reset releases.
// - disabled path drives chip-select out high, released when enabled.
// - low-line warning output follows the low-line comparator, forced low in battery backup.
// - aux fail output low while aux monitor is below its trip level.
// - battery-backup mode ignores watchdog kick and manual reset.

module supervisor_reset_watchdog_cegate #(
  parameter int unsigned RESET_TIMEOUT_CYCLES = `SUP_RESET_TIMEOUT_CYC,
  parameter int unsigned WATCHDOG_CYCLES = `SUP_WATCHDOG_CYC,
  parameter int unsigned GATE_DELAY_CYCLES = `SUP_GATE_DELAY_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = `SUP_DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  // comparator levels
  input wire logic supply_low,
  input wire logic low_line_trip,
  input wire logic aux_below_trip,
  input wire logic battery_backup,
  // system pins
  input wire logic manual_reset_n,
  input wire logic watchdog_kick,
  input wire logic watchdog_kick_float,
  input wire logic chip_select_in_n,
  // outputs
  output logic reset_n,
  output logic reset,
  output logic watchdog_fault_n,
  output logic low_line_n,
  output logic aux_fail_n,
  output logic chip_select_out_n,
  output logic chip_select_pullup,
  output logic chip_select_in_hiz
);

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [`SUP_SYNC_W-1:0] raw_in;
  logic [`SUP_SYNC_W-1:0] sync_in;

  assign raw_in[`SUP_SYNC_SUPPLY_LOW] = supply_low;
  assign raw_in[`SUP_SYNC_LOW_LINE] = low_line_trip;
  assign raw_in[`SUP_SYNC_AUX_BELOW] = aux_below_trip;
  assign raw_in[`SUP_SYNC_MR_N] = manual_reset_n;
  assign raw_in[`SUP_SYNC_KICK] = watchdog_kick;
  assign raw_in[`SUP_SYNC_KICK_FLOAT] = watchdog_kick_float;
  assign raw_in[`SUP_SYNC_BACKUP] = battery_backup;
  assign raw_in[`SUP_SYNC_CS_IN_N] = chip_select_in_n;

  // every pin and comparator level crosses here before logic reads it
  sync_2ff #(
    .W(`SUP_SYNC_W)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d(raw_in),
    .q(sync_in)
  );

  wire supply_low_s = sync_in[`SUP_SYNC_SUPPLY_LOW];
  wire low_line_s = sync_in[`SUP_SYNC_LOW_LINE];
  wire aux_below_s = sync_in[`SUP_SYNC_AUX_BELOW];
  wire mr_n_s = sync_in[`SUP_SYNC_MR_N];
  wire kick_s = sync_in[`SUP_SYNC_KICK];
  wire kick_float_s = sync_in[`SUP_SYNC_KICK_FLOAT];
  wire backup_s = sync_in[`SUP_SYNC_BACKUP];
  wire cs_in_n_s = sync_in[`SUP_SYNC_CS_IN_N];

  // ****************************************
  // manual reset debounce
  // ****************************************
  // the synchroniser resets low, so mr_n_s starts low; treat the
  // accepted level as released until a stable low is seen
  logic mr_prev_r;
  logic mr_low_r;
  logic mr_stable;

  wire mr_changed = (mr_n_s != mr_prev_r);

  cycle_timer #(
    .W(`SUP_TIMER_W)
  ) u_debounce (
    .clk(clk),
    .rst(rst),
    .clear(mr_changed),
    .run(1'h1),
    .limit(`SUP_TIMER_W'(DEBOUNCE_CYCLES)),
    .done(mr_stable)
  );

  // done lags a cycle, so a level that just changed is not taken
  wire mr_settled = mr_stable && !mr_changed;

  // short bounces never settle, and the ones that do only
  // restart the reset timeout, so one reset pulse results;
  // a low taken in backup is dropped, so leaving backup
  // cannot fire a stray reset
  always_ff @(posedge clk) begin
    if (rst) begin
      mr_prev_r <= 1'h1;
      mr_low_r <= 1'h0;
    end else begin
      mr_prev_r <= mr_n_s;
      if (backup_s) begin
        mr_low_r <= 1'h0;
      end else if (mr_settled) begin
        mr_low_r <= !mr_n_s;
      end
    end
  end

  // ****************************************
  // reset generation
  // ****************************************
  logic reset_r;
  logic timeout_done;

  wire mr_cause = mr_low_r && !backup_s;
  wire reset_cause = supply_low_s || mr_cause;

  // cause clears the timer, so a fresh dip restarts the full timeout
  cycle_timer #(
    .W(`SUP_TIMER_W)
  ) u_reset_timer (
    .clk(clk),
    .rst(rst),
    .clear(reset_cause),
    .run(!reset_cause),
    .limit(`SUP_TIMER_W'(RESET_TIMEOUT_CYCLES)),
    .done(timeout_done)
  );

  wire reset_nxt = reset_cause || !timeout_done;

  // reset_r starts high, so power-up runs the full timeout
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_r <= 1'h1;
    end else begin
      reset_r <= reset_nxt;
    end
  end

  assign reset_n = !reset_r;
  assign reset = reset_r;

  // ****************************************
  // watchdog
  // ****************************************
  logic kick_prev_r;
  logic wd_expired;
  logic fault_n_r;

  // the kick pin is not watched in backup, so its edges do not count
  wire kick_edge = (kick_s != kick_prev_r) && !backup_s;
  wire wd_disabled = supply_low_s || kick_float_s || backup_s;
  wire wd_clear = reset_r || kick_edge || wd_disabled;

  cycle_timer #(
    .W(`SUP_TIMER_W)
  ) u_wd_timer (
    .clk(clk),
    .rst(rst),
    .clear(wd_clear),
    .run(1'h1),
    .limit(`SUP_TIMER_W'(WATCHDOG_CYCLES)),
    .done(wd_expired)
  );

  // timer saturates, so fault holds until a clearing event
  always_ff @(posedge clk) begin
    if (rst) begin
      kick_prev_r <= 1'h0;
      fault_n_r <= 1'h1;
    end else begin
      kick_prev_r <= kick_s;
      if (wd_clear) begin
        fault_n_r <= 1'h1;
      end else if (wd_expired) begin
        fault_n_r <= 1'h0;
      end
    end
  end

  assign watchdog_fault_n = fault_n_r;

  // ****************************************
  // chip-select gate
  // ****************************************
  supervisor_pkg::gate_state_t gate_r;
  supervisor_pkg::gate_state_t gate_nxt;
  logic gate_delay_done;
  logic cs_out_n_r;

  wire gate_pending = (gate_r == supervisor_pkg::GATE_PENDING);

  // delay only counts while a power-down disable is pending
  cycle_timer #(
    .W(`SUP_TIMER_W)
  ) u_gate_delay (
    .clk(clk),
    .rst(rst),
    .clear(!gate_pending),
    .run(1'h1),
    .limit(`SUP_TIMER_W'(GATE_DELAY_CYCLES)),
    .done(gate_delay_done)
  );

  // a supply-low cause waits out the delay, any other cause blocks at once
  always_comb begin
    gate_nxt = gate_r;
    unique case (gate_r)
      supervisor_pkg::GATE_PASS: begin
        if (reset_nxt && supply_low_s) begin
          gate_nxt = supervisor_pkg::GATE_PENDING;
        end else if (reset_nxt) begin
          gate_nxt = supervisor_pkg::GATE_BLOCKED;
        end
      end
      supervisor_pkg::GATE_PENDING: begin
        if (!reset_nxt) begin
          gate_nxt = supervisor_pkg::GATE_PASS;
        end else if (gate_delay_done) begin
          gate_nxt = supervisor_pkg::GATE_BLOCKED;
        end
      end
      supervisor_pkg::GATE_BLOCKED: begin
        if (!reset_nxt) begin
          gate_nxt = supervisor_pkg::GATE_PASS;
        end
      end
      default: begin
        gate_nxt = supervisor_pkg::GATE_BLOCKED;
      end
    endcase
  end

  // power-up starts blocked, so input activity is ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      gate_r <= supervisor_pkg::GATE_BLOCKED;
    end else begin
      gate_r <= gate_nxt;
    end
  end

  wire gate_blocked = (gate_nxt == supervisor_pkg::GATE_BLOCKED);
  // blocked path parks the output high, so ram sees no select
  wire cs_out_n_nxt = gate_blocked ? 1'h1 : cs_in_n_s;

  // pending still passes chip-select: ram finishes its cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_out_n_r <= 1'h1;
      chip_select_pullup <= 1'h1;
      chip_select_in_hiz <= 1'h1;
    end else begin
      cs_out_n_r <= cs_out_n_nxt;
      chip_select_pullup <= gate_blocked;
      chip_select_in_hiz <= gate_blocked;
    end
  end

  assign chip_select_out_n = cs_out_n_r;

  // ****************************************
  // warning outputs
  // ****************************************
  // backup forces the early warning low, the aux path stays live
  wire low_line_n_nxt = !(low_line_s || backup_s);
  wire aux_fail_n_nxt = !aux_below_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      low_line_n <= 1'h0;
      aux_fail_n <= 1'h1;
    end else begin
      low_line_n <= low_line_n_nxt;
      aux_fail_n <= aux_fail_n_nxt;
    end
  end

endmodule

`default_nettype wire

// ---- verification/supervisor_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// port checks
// ****************************************
module supervisor_asserts #(
  parameter int unsigned WATCHDOG_CYCLES = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic supply_low,
  input wire logic low_line_trip,
  input wire logic aux_below_trip,
  input wire logic battery_backup,
  input wire logic watchdog_kick,
  input wire logic watchdog_kick_float,
  input wire logic chip_select_in_n,
  input wire logic reset_n,
  input wire logic reset,
  input wire logic watchdog_fault_n,
  input wire logic low_line_n,
  input wire logic aux_fail_n,
  input wire logic chip_select_out_n,
  input wire logic chip_select_pullup,
  input wire logic chip_select_in_hiz
);
  logic [31:0] quiet_r;
  logic [2:0] up_r;
  logic kick_r;
  // quiet counts at the pins, so it runs ahead of the synchronised view
  always_ff @(posedge clk) begin
    kick_r <= watchdog_kick;
    if (rst) begin
      up_r <= 3'h0;
    end else if (up_r != 3'h7) begin
      up_r <= up_r + 3'h1;
    end
    if (rst || reset || supply_low || watchdog_kick_float || battery_backup || watchdog_kick != kick_r) begin
      quiet_r <= 32'h0;
    end else begin
      quiet_r <= quiet_r + 32'h1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_reset_pair: assert property (reset_n == !reset) else $error("reset pair differs");
  a_supply_reset: assert property ($rose(supply_low) |-> ##[1:4] reset) else $error("no reset");
  a_aux_follows: assert property (up_r == 3'h7 |-> aux_fail_n == !$past(aux_below_trip, 3))
    else $error("aux fail wrong");
  a_low_line: assert property (up_r == 3'h7 |->
    low_line_n == !($past(low_line_trip, 3) || $past(battery_backup, 3))) else $error("low line wrong");
  a_fault_reset: assert property (reset [*3] |-> watchdog_fault_n) else $error("fault in reset");
  a_fault_timer: assert property ($fell(watchdog_fault_n) |-> quiet_r >= WATCHDOG_CYCLES)
    else $error("fault early");
  a_fault_hold: assert property (!watchdog_fault_n && !reset && quiet_r > 32'h4 |=> !watchdog_fault_n)
    else $error("fault dropped");
  a_cs_blocked: assert property (chip_select_pullup |-> chip_select_out_n && chip_select_in_hiz)
    else $error("cs not parked");
  a_cs_pass: assert property (!chip_select_pullup && !$past(chip_select_pullup) |->
    chip_select_out_n == $past(chip_select_in_n, 3)) else $error("cs not passed");
  a_gate_delay: assert property ($rose(reset) |-> ##[0:14] chip_select_pullup) else $error("gate open");
  a_gate_reopen: assert property ($fell(chip_select_pullup) |-> !reset) else $error("gate early");
  cover property ($fell(watchdog_fault_n));
  cover property ($fell(reset));
  cover property (supply_low && $rose(chip_select_pullup));
endmodule
bind supervisor_reset_watchdog_cegate supervisor_asserts #(.WATCHDOG_CYCLES(WATCHDOG_CYCLES)) u_chk (.clk(clk),
  .rst(rst), .supply_low(supply_low), .low_line_trip(low_line_trip), .aux_below_trip(aux_below_trip),
  .battery_backup(battery_backup), .watchdog_kick(watchdog_kick), .watchdog_kick_float(watchdog_kick_float),
  .chip_select_in_n(chip_select_in_n), .reset_n(reset_n), .reset(reset), .watchdog_fault_n(watchdog_fault_n),
  .low_line_n(low_line_n), .aux_fail_n(aux_fail_n), .chip_select_out_n(chip_select_out_n),
  .chip_select_pullup(chip_select_pullup), .chip_select_in_hiz(chip_select_in_hiz));
`default_nettype wire

// ---- verification/cpu_ram_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// processor and ram select
// ****************************************
module cpu_ram_model (
  input wire logic clk,
  input wire logic kick_on,
  output logic watchdog_kick,
  output logic chip_select_in_n
);
  logic [3:0] cnt = 4'h0;
  initial begin
    watchdog_kick = 1'b0;
    chip_select_in_n = 1'b1;
  end
  // kick every 16 cycles, well inside the watchdog period
  always @(posedge clk) begin
    cnt <= #1 cnt + 4'h1;
    chip_select_in_n <= #1 cnt[1] ^ cnt[3];
    if (kick_on && cnt == 4'hF) begin
      watchdog_kick <= #1 !watchdog_kick;
    end
  end
endmodule
`default_nettype wire

// ---- verification/supervisor_reset_watchdog_cegate_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin error_cnt++; $display("Error %0t %s", $time, m); end end
module supervisor_reset_watchdog_cegate_tb_top;
  localparam int RT = 50;
  localparam int WD = 200;
  logic clk = 1'b0, rst = 1'b1, supply_low = 1'b0, low_line_trip = 1'b0, aux_below_trip = 1'b0;
  logic battery_backup = 1'b0, manual_reset_n = 1'b1, watchdog_kick_float = 1'b0, kick_on = 1'b1;
  logic watchdog_kick, chip_select_in_n, reset_n, reset, watchdog_fault_n, low_line_n, aux_fail_n;
  logic chip_select_out_n, chip_select_pullup, chip_select_in_hiz, pu_q = 1'b1;
  logic [7:0] lfsr = 8'h5A;
  logic aux_q[$], ll_q[$], cs_q[$];
  int error_cnt = 0, n_checks = 0, up = 0, i;
  always #20 clk = ~clk;
  supervisor_reset_watchdog_cegate #(.RESET_TIMEOUT_CYCLES(RT), .WATCHDOG_CYCLES(WD),
    .GATE_DELAY_CYCLES(10), .DEBOUNCE_CYCLES(4)) uut (.clk(clk), .rst(rst), .supply_low(supply_low),
    .low_line_trip(low_line_trip), .aux_below_trip(aux_below_trip), .battery_backup(battery_backup),
    .manual_reset_n(manual_reset_n), .watchdog_kick(watchdog_kick), .watchdog_kick_float(watchdog_kick_float),
    .chip_select_in_n(chip_select_in_n), .reset_n(reset_n), .reset(reset), .watchdog_fault_n(watchdog_fault_n),
    .low_line_n(low_line_n), .aux_fail_n(aux_fail_n), .chip_select_out_n(chip_select_out_n),
    .chip_select_pullup(chip_select_pullup), .chip_select_in_hiz(chip_select_in_hiz));
  cpu_ram_model cpu (.clk(clk), .kick_on(kick_on), .watchdog_kick(watchdog_kick),
    .chip_select_in_n(chip_select_in_n));
  // ****************************************
  // reference model
  // ****************************************
  always @(posedge clk) begin
    aux_q.push_back(aux_below_trip);
    ll_q.push_back(low_line_trip | battery_backup);
    cs_q.push_back(chip_select_in_n);
    if (aux_q.size() > 3) begin
      aux_q.pop_front();
      ll_q.pop_front();
      cs_q.pop_front();
    end
    up = rst ? 0 : up + 1;
    #1;
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    aux_below_trip = lfsr[0];
    low_line_trip = lfsr[3] & lfsr[5];
  end
  always @(negedge clk) begin
    if (up > 6) begin
      `CHK(aux_fail_n, !aux_q[0], "aux fail")
      `CHK(low_line_n, !ll_q[0], "low line")
      `CHK(reset_n, !reset, "reset pair")
      if (!chip_select_pullup && !pu_q) `CHK(chip_select_out_n, cs_q[0], "cs pass")
    end
    pu_q = chip_select_pullup;
  end
  // ****************************************
  // sequence
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // waits on reset, or on the fault output when wd is set
  task automatic wait_out(input bit wd, input logic v, input int lo, input int hi);
    int k;
    k = 0;
    while ((wd ? watchdog_fault_n : reset) !== v && k < hi) begin
      step(1);
      k++;
    end
    `CHK(k >= lo && k < hi, 1'b1, "wait bound")
    if (k >= hi) end_sim();
  endtask
  initial begin
    step(20);
    rst = 1'b0;
    step(5);
    `CHK(chip_select_pullup, 1'b1, "power-up gate")
    `CHK(chip_select_out_n, 1'b1, "power-up cs")
    wait_out(0, 1'b0, RT - 5, RT + 8);
    `CHK({chip_select_pullup, chip_select_in_hiz}, 2'b00, "gate release")
    step(WD + 100);
    `CHK(watchdog_fault_n, 1'b1, "kicked")
    kick_on = 1'b0;
    wait_out(1, 1'b0, WD - 20, WD + 20);
    step(50);
    `CHK(watchdog_fault_n, 1'b0, "fault held")
    kick_on = 1'b1;
    wait_out(1, 1'b1, 0, 25);
    kick_on = 1'b0;
    watchdog_kick_float = 1'b1;
    step(WD + 40);
    `CHK(watchdog_fault_n, 1'b1, "float")
    watchdog_kick_float = 1'b0;
    battery_backup = 1'b1;
    manual_reset_n = 1'b0;
    step(WD + 40);
    `CHK({reset, watchdog_fault_n}, 2'b01, "backup")
    manual_reset_n = 1'b1;
    battery_backup = 1'b0;
    kick_on = 1'b1;
    step(10);
    for (i = 0; i < 6; i++) begin
      manual_reset_n = i[0];
      step(2);
    end
    `CHK(reset, 1'b0, "bounce")
    manual_reset_n = 1'b0;
    wait_out(0, 1'b1, 3, 14);
    `CHK(chip_select_pullup, 1'b1, "manual gate")
    for (i = 0; i < 30; i++) begin
      step(1);
      `CHK(reset, 1'b1, "manual hold")
    end
    manual_reset_n = 1'b1;
    wait_out(0, 1'b0, RT, RT + 14);
    step(20);
    supply_low = 1'b1;
    wait_out(0, 1'b1, 1, 6);
    step(3);
    `CHK(chip_select_pullup, 1'b0, "gate delay")
    step(12);
    `CHK(chip_select_pullup, 1'b1, "gate off")
    `CHK(watchdog_fault_n, 1'b1, "supply low")
    supply_low = 1'b0;
    step(RT / 2);
    supply_low = 1'b1;
    step(3);
    supply_low = 1'b0;
    wait_out(0, 1'b0, RT - 2, RT + 10);
    step(10);
    end_sim();
  end
endmodule
`default_nettype wire
